// ==== hdl/jtag_cfg_pkg.sv ====
// Constants, encodings and state types for the boundary-scan configuration port.
// Assumes a single TAP per device; opcode values are local to this code base.
package jtag_cfg_pkg;
    localparam int IR_W = 10;
    localparam int ID_W = 32;
    localparam int IO_W = 8;
    localparam int CNT_W = 16;
    localparam int MSEL_W = 4;

    localparam logic [IR_W-1:0] OP_BYPASS = 10'h3FF;
    localparam logic [IR_W-1:0] OP_IDCODE = 10'h006;
    localparam logic [IR_W-1:0] OP_SAMPLE = 10'h005;
    localparam logic [IR_W-1:0] OP_EXTEST = 10'h00F;
    localparam logic [IR_W-1:0] OP_PROGRAM = 10'h002;
    localparam logic [IR_W-1:0] OP_STARTUP = 10'h003;
    localparam logic [IR_W-1:0] OP_STATUS = 10'h004;
    localparam logic [IR_W-1:0] OP_PARK = 10'h2D0;
    localparam logic [IR_W-1:0] OP_IO_CFG = 10'h00D;
    localparam logic [IR_W-1:0] OP_RESUME = 10'h2B0;
    localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;

    // Identification value is arbitrary
    localparam logic [ID_W-1:0] IDCODE_VALUE = 32'h0000_1235;
    localparam logic [CNT_W-1:0] BITSTREAM_BITS_DEF = 16'h0040;

    localparam logic [MSEL_W-1:0] MSEL_JTAG_ONLY = 4'h0;
    localparam logic [MSEL_W-1:0] MSEL_ACTIVE_SERIAL = 4'h1;
    localparam logic [MSEL_W-1:0] MSEL_ACTIVE_PARALLEL = 4'h2;

    // Divider terminal count; the serial load clock toggles every SLC_HALF + 1 system clocks
    localparam logic [1:0] SLC_HALF = 2'h2;
    localparam logic [1:0] BOOT_WAIT = 2'h3;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;

    typedef enum logic [2:0] {
        CTL_BOOT, CTL_IDLE, CTL_ACTIVE, CTL_PASSIVE, CTL_PARKED
    } ctl_state_t;
endpackage : jtag_cfg_pkg

// ==== hdl/jtag_configuration_port.sv ====
// Boundary-scan TAP with bitstream load, status readback and mode controller.
// Assumes tck comes from the external host and may stop between scans;
// clk is the device system clock; rstn is asynchronous and active low.
//
// Functional notes
// - Untargeted device passes TDI to TDO through one bypass bit, state untouched.
// - Bitstream bits leave TDO exactly one TCK cycle after entering TDI.
// - Done flag rises on successful load; host reads it, low means failure.
// - One Run-Test/Idle TCK under the STARTUP instruction, after the last bit, performs device initialization.
// - Boundary-scan operations work before, during and after configuration, except EXTEST during an unparked load.
// - BYPASS, IDCODE and SAMPLE run during configuration without disturbing it.
// - I/O-reconfigure sets I/O buffers over JTAG once configuration is parked.
// - Park instruction forces active configuration controllers idle.
// - Resume instruction reactivates a parked active controller.
// - Chip-wide clear and output enable never affect JTAG operations.
// - TDI captured on TCK rise, TDO launched on TCK fall.
// - TDO is released whenever nothing is being shifted out.
// - JTAG overrides other modes; starting it aborts a passive serial load.
// - TAP state changes on TCK rise using TMS sampled there.
`timescale 1ns/10ps
module jtag_configuration_port #(
    parameter logic [jtag_cfg_pkg::CNT_W-1:0] BITSTREAM_BITS = jtag_cfg_pkg::BITSTREAM_BITS_DEF
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Test access port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Device pins seen by the configuration logic
    input wire logic [jtag_cfg_pkg::MSEL_W-1:0] scheme_select_pins,
    input wire logic chip_wide_clear_low,
    input wire logic chip_wide_output_enable,
    input wire logic [jtag_cfg_pkg::IO_W-1:0] io_pins_in,
    // Configuration status and controls
    output logic config_done_flag,
    output logic config_status_low,
    output logic serial_load_clock,
    output logic passive_load_abort,
    output logic ctl_parked,
    output logic user_io_enable,
    output logic [jtag_cfg_pkg::IO_W-1:0] io_cfg_value,
    output logic io_cfg_own
);
    typedef struct packed {
        jtag_cfg_pkg::tap_state_t tap;
        logic [jtag_cfg_pkg::IR_W-1:0] ir;
        logic [jtag_cfg_pkg::IR_W-1:0] ir_sh;
        logic stage;
        logic [jtag_cfg_pkg::ID_W-1:0] id_sh;
        logic [jtag_cfg_pkg::IO_W-1:0] io_sh;
        logic [jtag_cfg_pkg::IO_W-1:0] io_cfg;
        logic [jtag_cfg_pkg::IO_W-1:0] io_meta, io_sync;
        logic [jtag_cfg_pkg::CNT_W-1:0] cnt;
        logic loaded, done, prog, park, io_own;
    } tck_state_t;
    typedef struct packed {
        jtag_cfg_pkg::ctl_state_t ctl;
        logic [1:0] boot;
        logic [jtag_cfg_pkg::MSEL_W-1:0] msel_m, msel_s;
        logic prog_m, prog_s;
        logic park_m, park_s;
        logic oe_m, oe_s;
        logic clr_m, clr_s;
        logic resume_active;
        logic [1:0] div;
        logic slc;
        logic abort;
        logic status_low;
        logic user_oe, parked;
    } clk_state_t;
    typedef struct packed {
        logic tdo;
        logic oe;
    } out_state_t;

    tck_state_t t_r, t_nxt;
    clk_state_t c_r, c_nxt;
    out_state_t o_r;
    logic [1:0] crst_r, trst_r;
    logic [jtag_cfg_pkg::IR_W-1:0] eff_ir;
    logic restricted;

    // Reset release is synchronised separately into each domain
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crst_r <= 2'h0;
        end else begin
            crst_r <= {crst_r[0], 1'b1};
        end
    end

    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            trst_r <= 2'h0;
        end else begin
            trst_r <= {trst_r[0], 1'b1};
        end
    end

    // Anything outside the always-allowed set is held off while a load runs unparked
    always_comb begin
        restricted = t_r.prog && !t_r.park;
        unique case (t_r.ir)
            jtag_cfg_pkg::OP_BYPASS, jtag_cfg_pkg::OP_IDCODE, jtag_cfg_pkg::OP_SAMPLE,
            jtag_cfg_pkg::OP_PROGRAM, jtag_cfg_pkg::OP_STARTUP,
            jtag_cfg_pkg::OP_STATUS, jtag_cfg_pkg::OP_PARK: eff_ir = t_r.ir;
            jtag_cfg_pkg::OP_IO_CFG: begin
                eff_ir = t_r.park ? t_r.ir : jtag_cfg_pkg::OP_BYPASS;
            end
            jtag_cfg_pkg::OP_EXTEST, jtag_cfg_pkg::OP_RESUME: begin
                eff_ir = restricted ? jtag_cfg_pkg::OP_BYPASS : t_r.ir;
            end
            default: eff_ir = jtag_cfg_pkg::OP_BYPASS;
        endcase
    end

    // TAP domain
    always_comb begin
        t_nxt = t_r;
        t_nxt.io_meta = io_pins_in;
        t_nxt.io_sync = t_r.io_meta;
        unique case (t_r.tap)
            jtag_cfg_pkg::TLR: t_nxt.tap = tms ? jtag_cfg_pkg::TLR : jtag_cfg_pkg::RTI;
            jtag_cfg_pkg::RTI: t_nxt.tap = tms ? jtag_cfg_pkg::SEL_DR : jtag_cfg_pkg::RTI;
            jtag_cfg_pkg::SEL_DR: t_nxt.tap = tms ? jtag_cfg_pkg::SEL_IR : jtag_cfg_pkg::CAP_DR;
            jtag_cfg_pkg::CAP_DR: t_nxt.tap = tms ? jtag_cfg_pkg::EX1_DR : jtag_cfg_pkg::SH_DR;
            jtag_cfg_pkg::SH_DR: t_nxt.tap = tms ? jtag_cfg_pkg::EX1_DR : jtag_cfg_pkg::SH_DR;
            jtag_cfg_pkg::EX1_DR: t_nxt.tap = tms ? jtag_cfg_pkg::UPD_DR : jtag_cfg_pkg::PA_DR;
            jtag_cfg_pkg::PA_DR: t_nxt.tap = tms ? jtag_cfg_pkg::EX2_DR : jtag_cfg_pkg::PA_DR;
            jtag_cfg_pkg::EX2_DR: t_nxt.tap = tms ? jtag_cfg_pkg::UPD_DR : jtag_cfg_pkg::SH_DR;
            jtag_cfg_pkg::UPD_DR: t_nxt.tap = tms ? jtag_cfg_pkg::SEL_DR : jtag_cfg_pkg::RTI;
            jtag_cfg_pkg::SEL_IR: t_nxt.tap = tms ? jtag_cfg_pkg::TLR : jtag_cfg_pkg::CAP_IR;
            jtag_cfg_pkg::CAP_IR: t_nxt.tap = tms ? jtag_cfg_pkg::EX1_IR : jtag_cfg_pkg::SH_IR;
            jtag_cfg_pkg::SH_IR: t_nxt.tap = tms ? jtag_cfg_pkg::EX1_IR : jtag_cfg_pkg::SH_IR;
            jtag_cfg_pkg::EX1_IR: t_nxt.tap = tms ? jtag_cfg_pkg::UPD_IR : jtag_cfg_pkg::PA_IR;
            jtag_cfg_pkg::PA_IR: t_nxt.tap = tms ? jtag_cfg_pkg::EX2_IR : jtag_cfg_pkg::PA_IR;
            jtag_cfg_pkg::EX2_IR: t_nxt.tap = tms ? jtag_cfg_pkg::UPD_IR : jtag_cfg_pkg::SH_IR;
            jtag_cfg_pkg::UPD_IR: t_nxt.tap = tms ? jtag_cfg_pkg::SEL_DR : jtag_cfg_pkg::RTI;
        endcase
        unique case (t_r.tap)
            jtag_cfg_pkg::TLR: t_nxt.ir = jtag_cfg_pkg::OP_IDCODE;
            jtag_cfg_pkg::CAP_IR: t_nxt.ir_sh = jtag_cfg_pkg::IR_CAPTURE;
            jtag_cfg_pkg::SH_IR: t_nxt.ir_sh = {tdi, t_r.ir_sh[jtag_cfg_pkg::IR_W-1:1]};
            jtag_cfg_pkg::UPD_IR: begin
                t_nxt.ir = t_r.ir_sh;
                if (t_r.ir_sh == jtag_cfg_pkg::OP_PROGRAM) begin
                    // A fresh load starts over and overrides other modes
                    t_nxt.prog = 1'b1;
                    t_nxt.cnt = '0;
                    t_nxt.loaded = 1'b0;
                    t_nxt.done = 1'b0;
                end
                if (t_r.ir_sh == jtag_cfg_pkg::OP_PARK) begin
                    t_nxt.park = 1'b1;
                end
                if (t_r.ir_sh == jtag_cfg_pkg::OP_RESUME && !restricted) begin
                    t_nxt.park = 1'b0;
                    t_nxt.io_own = 1'b0;
                end
            end
            jtag_cfg_pkg::RTI: begin
                if (t_r.ir == jtag_cfg_pkg::OP_STARTUP && t_r.loaded && !t_r.done) begin
                    // The clock after the last bit completes initialization
                    t_nxt.done = 1'b1;
                    t_nxt.prog = 1'b0;
                end
            end
            jtag_cfg_pkg::CAP_DR: begin
                unique case (eff_ir)
                    jtag_cfg_pkg::OP_IDCODE: t_nxt.id_sh = jtag_cfg_pkg::IDCODE_VALUE;
                    jtag_cfg_pkg::OP_SAMPLE, jtag_cfg_pkg::OP_EXTEST,
                    jtag_cfg_pkg::OP_IO_CFG: t_nxt.io_sh = t_r.io_sync;
                    jtag_cfg_pkg::OP_STATUS: t_nxt.stage = t_r.done;
                    default: t_nxt.stage = 1'b0;
                endcase
            end
            jtag_cfg_pkg::SH_DR: begin
                unique case (eff_ir)
                    jtag_cfg_pkg::OP_IDCODE: begin
                        t_nxt.id_sh = {tdi, t_r.id_sh[jtag_cfg_pkg::ID_W-1:1]};
                    end
                    jtag_cfg_pkg::OP_SAMPLE, jtag_cfg_pkg::OP_EXTEST,
                    jtag_cfg_pkg::OP_IO_CFG: begin
                        t_nxt.io_sh = {tdi, t_r.io_sh[jtag_cfg_pkg::IO_W-1:1]};
                    end
                    jtag_cfg_pkg::OP_PROGRAM: begin
                        t_nxt.stage = tdi;
                        if (!t_r.loaded) begin
                            t_nxt.cnt = t_r.cnt + 16'h0001;
                            t_nxt.loaded = (t_r.cnt + 16'h0001) == BITSTREAM_BITS;
                        end
                    end
                    default: t_nxt.stage = tdi;
                endcase
            end
            jtag_cfg_pkg::UPD_DR: begin
                if (eff_ir == jtag_cfg_pkg::OP_IO_CFG || eff_ir == jtag_cfg_pkg::OP_EXTEST) begin
                    t_nxt.io_cfg = t_r.io_sh;
                    t_nxt.io_own = 1'b1;
                end
            end
            default: t_nxt.ir = t_r.ir;
        endcase
    end

    // chip_wide_clear_low never reaches this reset path
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            t_r <= '0;
        end else if (!trst_r[1]) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    // Output launch on the falling edge gives the host a full half period of setup
    always_ff @(negedge tck or negedge rstn) begin
        if (!rstn) begin
            o_r <= '0;
        end else begin
            o_r.oe <= t_r.tap == jtag_cfg_pkg::SH_IR || t_r.tap == jtag_cfg_pkg::SH_DR;
            if (t_r.tap == jtag_cfg_pkg::SH_IR) begin
                o_r.tdo <= t_r.ir_sh[0];
            end else if (eff_ir == jtag_cfg_pkg::OP_IDCODE) begin
                o_r.tdo <= t_r.id_sh[0];
            end else if (eff_ir == jtag_cfg_pkg::OP_SAMPLE || eff_ir == jtag_cfg_pkg::OP_EXTEST
                         || eff_ir == jtag_cfg_pkg::OP_IO_CFG) begin
                o_r.tdo <= t_r.io_sh[0];
            end else begin
                o_r.tdo <= t_r.stage;
            end
        end
    end

    // System clock domain: mode controller
    always_comb begin
        c_nxt = c_r;
        c_nxt.msel_m = scheme_select_pins;
        c_nxt.msel_s = c_r.msel_m;
        c_nxt.prog_m = t_r.prog;
        c_nxt.prog_s = c_r.prog_m;
        c_nxt.park_m = t_r.park;
        c_nxt.park_s = c_r.park_m;
        c_nxt.oe_m = chip_wide_output_enable;
        c_nxt.oe_s = c_r.oe_m;
        c_nxt.clr_m = chip_wide_clear_low;
        c_nxt.clr_s = c_r.clr_m;
        c_nxt.abort = 1'b0;
        c_nxt.user_oe = c_r.oe_s && c_r.clr_s;
        c_nxt.status_low = c_r.ctl != jtag_cfg_pkg::CTL_PARKED;
        c_nxt.slc = 1'b0;
        unique case (c_r.ctl)
            jtag_cfg_pkg::CTL_BOOT: begin
                c_nxt.boot = c_r.boot + 2'h1;
                if (c_r.boot == jtag_cfg_pkg::BOOT_WAIT) begin
                    c_nxt.resume_active = c_r.msel_s == jtag_cfg_pkg::MSEL_ACTIVE_SERIAL
                        || c_r.msel_s == jtag_cfg_pkg::MSEL_ACTIVE_PARALLEL;
                    if (c_r.msel_s == jtag_cfg_pkg::MSEL_JTAG_ONLY) begin
                        c_nxt.ctl = jtag_cfg_pkg::CTL_IDLE;
                    end else if (c_nxt.resume_active) begin
                        c_nxt.ctl = jtag_cfg_pkg::CTL_ACTIVE;
                    end else begin
                        c_nxt.ctl = jtag_cfg_pkg::CTL_PASSIVE;
                    end
                end
            end
            jtag_cfg_pkg::CTL_IDLE: begin
                if (c_r.park_s) begin
                    c_nxt.ctl = jtag_cfg_pkg::CTL_PARKED;
                end
            end
            jtag_cfg_pkg::CTL_ACTIVE: begin
                // JTAG wins: no serial load clock while a JTAG load runs
                c_nxt.div = c_r.div + 2'h1;
                c_nxt.slc = c_r.slc;
                if (c_r.div == jtag_cfg_pkg::SLC_HALF) begin
                    c_nxt.div = 2'h0;
                    c_nxt.slc = !c_r.slc;
                end
                if (c_r.park_s) begin
                    c_nxt.ctl = jtag_cfg_pkg::CTL_PARKED;
                end else if (c_r.prog_s) begin
                    c_nxt.ctl = jtag_cfg_pkg::CTL_IDLE;
                end
            end
            jtag_cfg_pkg::CTL_PASSIVE: begin
                if (c_r.park_s) begin
                    c_nxt.ctl = jtag_cfg_pkg::CTL_PARKED;
                end else if (c_r.prog_s) begin
                    c_nxt.ctl = jtag_cfg_pkg::CTL_IDLE;
                    c_nxt.abort = 1'b1;
                end
            end
            jtag_cfg_pkg::CTL_PARKED: begin
                if (!c_r.park_s) begin
                    c_nxt.ctl = c_r.resume_active ? jtag_cfg_pkg::CTL_ACTIVE
                                                  : jtag_cfg_pkg::CTL_IDLE;
                end
            end
            default: c_nxt.ctl = jtag_cfg_pkg::CTL_IDLE;
        endcase
        c_nxt.parked = c_nxt.ctl == jtag_cfg_pkg::CTL_PARKED;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            c_r <= '0;
        end else if (!crst_r[1]) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign tdo = o_r.tdo;
    assign tdo_oe = o_r.oe;
    assign config_done_flag = t_r.done;
    assign io_cfg_value = t_r.io_cfg;
    assign io_cfg_own = t_r.io_own;
    assign config_status_low = c_r.status_low;
    assign serial_load_clock = c_r.slc;
    assign passive_load_abort = c_r.abort;
    assign ctl_parked = c_r.parked;
    assign user_io_enable = c_r.user_oe;
endmodule : jtag_configuration_port

// ==== test/jtag_host.sv ====
// Behavioural boundary-scan host that owns tck, tms and tdi.
// Assumes the caller leaves the TAP in Run-Test/Idle between scans.
`timescale 1ns/10ps
module jtag_host (
    // Test access port, host side
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic smp;
    int ph = 0;
    // tck stands low between scans; tdi idles high as its pull-up would
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // Drive after the fall, sample tdo just before the rise
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #16;
        // A released tdo reads as the line's pull-up level
        o = tdo_oe ? tdo : 1'b1;
        tck = 1'b1;
        #16;
        tck = 1'b0;
    endtask : tick
    // Extra idle clocks after a load start the device
    task automatic run(input int n);
        for (int i = 0; i < n; i++) tick(1'b0, 1'b1, smp);
    endtask : run
    task automatic tap_reset();
        for (int i = 0; i < 5; i++) tick(1'b1, 1'b1, smp);
        tick(1'b0, 1'b1, smp);
    endtask : tap_reset
    // One IR or DR scan from and back to Run-Test/Idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] d,
                        output logic [31:0] q);
        q = '0;
        ph = ph % 7 + 1;
        #(ph);
        tick(1'b1, 1'b1, smp);
        if (ir) tick(1'b1, 1'b1, smp);
        tick(1'b0, 1'b1, smp);
        tick(1'b0, 1'b1, smp);
        for (int i = 0; i < n; i++) tick(i == n - 1, d[i], q[i]);
        tick(1'b1, 1'b1, smp);
        tick(1'b0, 1'b1, smp);
    endtask : scan
endmodule : jtag_host

// ==== test/jtag_port_checker.sv ====
// Pin-level assertions for the boundary-scan configuration port.
// Assumes it is bound into jtag_configuration_port and sees only its ports.
`timescale 1ns/10ps
module jtag_port_checker #(
    parameter logic [jtag_cfg_pkg::CNT_W-1:0] BITSTREAM_BITS = jtag_cfg_pkg::BITSTREAM_BITS_DEF
) (
    // Clocks and reset
    input logic clk,
    input logic rstn,
    input logic tck,
    // Watched pins
    input logic tms,
    input logic tdo,
    input logic tdo_oe,
    input logic chip_wide_clear_low,
    input logic chip_wide_output_enable,
    input logic config_done_flag,
    input logic config_status_low,
    input logic serial_load_clock,
    input logic passive_load_abort,
    input logic ctl_parked,
    input logic user_io_enable,
    input logic io_cfg_own
);
    logic tdo_r;
    logic oe_r;
    logic [2:0] age_r;
    // What stood at the rise must still stand at the fall
    always_ff @(posedge tck) begin
        tdo_r <= tdo;
        oe_r <= tdo_oe;
    end
    // Skips the pin synchroniser fill after each reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            age_r <= 3'h0;
        end else if (age_r != 3'h7) begin
            age_r <= age_r + 3'h1;
        end
    end
    tdo_stands_a: assert property (@(negedge tck) disable iff (!rstn) tdo == tdo_r)
        else $error("tdo moved away from the tck fall");
    oe_stands_a: assert property (@(negedge tck) disable iff (!rstn) tdo_oe == oe_r)
        else $error("tdo_oe moved away from the tck fall");
    done_rise_a: assert property (@(posedge tck) disable iff (!rstn)
        $rose(config_done_flag) |-> !$past(tms) && !$past(tms, 2) && $past(tms, 3))
        else $error("done rose outside the idle tck after update");
    park_status_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(ctl_parked) |=> !config_status_low)
        else $error("status not held low when parked");
    resume_status_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(ctl_parked) |=> config_status_low)
        else $error("status not released on resume");
    slc_halt_a: assert property (@(posedge clk) disable iff (!rstn)
        ctl_parked [*3] |-> $stable(serial_load_clock))
        else $error("serial load clock runs while parked");
    abort_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
        passive_load_abort |=> !passive_load_abort)
        else $error("abort pulse wider than one clock");
    user_io_a: assert property (@(posedge clk) disable iff (!rstn) age_r == 3'h7 |->
        user_io_enable == $past(chip_wide_output_enable && chip_wide_clear_low, 3))
        else $error("user io enable not the delayed gate");
    io_own_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(io_cfg_own) |-> ctl_parked)
        else $error("io ownership taken while not parked");
    cover property (@(posedge clk) $rose(ctl_parked));
    cover property (@(posedge tck) $rose(config_done_flag));
    cover property (@(posedge clk) passive_load_abort);
endmodule : jtag_port_checker

bind jtag_configuration_port jtag_port_checker #(.BITSTREAM_BITS(BITSTREAM_BITS)) i_chk (
    .clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
    .chip_wide_clear_low(chip_wide_clear_low), .chip_wide_output_enable(chip_wide_output_enable),
    .config_done_flag(config_done_flag), .config_status_low(config_status_low),
    .serial_load_clock(serial_load_clock), .passive_load_abort(passive_load_abort),
    .ctl_parked(ctl_parked), .user_io_enable(user_io_enable), .io_cfg_own(io_cfg_own)
);

// ==== test/tb.sv ====
// Self-checking bench for the boundary-scan configuration port.
// Assumes the host model drives the test access port from its own clock.
`timescale 1ns/10ps
module tb;
    localparam logic [jtag_cfg_pkg::CNT_W-1:0] NBITS = 16'h0008;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe;
    // Lone device in the chain: JTAG-only strap, clear released, outputs enabled
    logic [jtag_cfg_pkg::MSEL_W-1:0] strap = 4'h0;
    logic clr_low = 1'b1;
    logic oe = 1'b1;
    logic [7:0] pins = 8'hC3;
    logic done, stat_low, slc, abort_p, parked, uio, io_own;
    logic [7:0] io_val;
    logic [31:0] q;
    int err_count = 0;
    int cmp_count = 0;

    always #10 clk = ~clk;

    jtag_configuration_port #(.BITSTREAM_BITS(NBITS)) i_dut (
        .clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .scheme_select_pins(strap), .chip_wide_clear_low(clr_low),
        .chip_wide_output_enable(oe), .io_pins_in(pins), .config_done_flag(done),
        .config_status_low(stat_low), .serial_load_clock(slc), .passive_load_abort(abort_p),
        .ctl_parked(parked), .user_io_enable(uio), .io_cfg_value(io_val), .io_cfg_own(io_own)
    );
    jtag_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic ir(input logic [9:0] op);
        i_host.scan(1'b1, 10, {22'h0, op}, q);
    endtask : ir
    task automatic do_reset(input logic [3:0] s);
        @(posedge clk);
        rstn <= 1'b0;
        strap <= s;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        i_host.tap_reset();
    endtask : do_reset
    task automatic slc_runs(output logic r);
        logic p;
        r = 1'b0;
        p = slc;
        repeat (24) begin
            @(posedge clk);
            #1;
            if (slc !== p) r = 1'b1;
            p = slc;
        end
    endtask : slc_runs
    task automatic t_idcode();
        ir(jtag_cfg_pkg::OP_IDCODE);
        chk(q[9:0], jtag_cfg_pkg::IR_CAPTURE, "ir capture");
        i_host.scan(1'b0, 32, 32'h0, q);
        chk(q, jtag_cfg_pkg::IDCODE_VALUE, "idcode");
        #1;
        chk(tdo_oe, 1'b0, "tdo released");
        $display("idcode test done");
    endtask : t_idcode
    task automatic t_load(input int n, input logic ok);
        ir(jtag_cfg_pkg::OP_PROGRAM);
        chk(done, 1'b0, "done cleared");
        i_host.scan(1'b0, n, 32'h0000_9C6B, q);
        chk((q ^ (32'h9C6B << 1)) & ((32'h1 << n) - 32'h2), 32'h0, "load echo");
        ir(jtag_cfg_pkg::OP_SAMPLE);
        i_host.scan(1'b0, 8, 32'h0, q);
        chk(q[7:0], pins, "sample in load");
        ir(jtag_cfg_pkg::OP_STARTUP);
        chk(done, 1'b0, "done early");
        i_host.run(1);
        chk(done, ok, "done");
        ir(jtag_cfg_pkg::OP_STATUS);
        i_host.scan(1'b0, 1, 32'h0, q);
        chk(q[0], ok, "status bit");
        $display("load test done");
    endtask : t_load
    task automatic t_bypass();
        for (int i = 0; i < 2; i++) begin
            ir(i ? jtag_cfg_pkg::OP_IO_CFG : jtag_cfg_pkg::OP_BYPASS);
            i_host.scan(1'b0, 9, 32'h1A5, q);
            chk(q[8:1], 8'hA5, "bypass delay");
            chk(io_own, 1'b0, "io refused");
        end
        chk(done, 1'b1, "bypass kept state");
        $display("bypass test done");
    endtask : t_bypass
    task automatic t_chip();
        ir(jtag_cfg_pkg::OP_IDCODE);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            clr_low <= (i != 0);
            oe <= (i != 1);
            repeat (6) @(posedge clk);
            #1;
            chk(uio, i == 2, "user io gate");
            i_host.scan(1'b0, 32, 32'h0, q);
            chk(q, jtag_cfg_pkg::IDCODE_VALUE, "idcode under clear");
        end
        chk(done, 1'b1, "done kept");
        $display("chip-wide test done");
    endtask : t_chip
    task automatic t_park();
        logic r;
        do_reset(jtag_cfg_pkg::MSEL_ACTIVE_SERIAL);
        slc_runs(r);
        chk(r, 1'b1, "active clock runs");
        ir(jtag_cfg_pkg::OP_PARK);
        repeat (8) @(posedge clk);
        #1;
        chk(parked, 1'b1, "parked");
        chk(stat_low, 1'b0, "status held");
        slc_runs(r);
        chk(r, 1'b0, "clock idle");
        ir(jtag_cfg_pkg::OP_IO_CFG);
        i_host.scan(1'b0, 8, 32'h5A, q);
        chk(io_val, 8'h5A, "io config");
        chk(io_own, 1'b1, "io owned");
        ir(jtag_cfg_pkg::OP_RESUME);
        repeat (8) @(posedge clk);
        #1;
        chk(parked, 1'b0, "resumed");
        chk(stat_low, 1'b1, "status free");
        chk(io_own, 1'b0, "io returned");
        slc_runs(r);
        chk(r, 1'b1, "clock back");
        $display("park test done");
    endtask : t_park
    task automatic t_abort();
        logic seen;
        seen = 1'b0;
        do_reset(4'h3);
        fork
            ir(jtag_cfg_pkg::OP_PROGRAM);
            repeat (100) begin
                @(posedge clk);
                #1;
                if (abort_p === 1'b1) seen = 1'b1;
            end
        join
        chk(seen, 1'b1, "passive aborted");
        $display("abort test done");
    endtask : t_abort
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    initial begin
        do_reset(jtag_cfg_pkg::MSEL_JTAG_ONLY);
        t_idcode();
        t_load(NBITS, 1'b1);
        t_bypass();
        t_chip();
        t_load(4, 1'b0);
        t_park();
        t_abort();
        conclude();
    end
    // The tests need well under 60 us; allow ample margin
    initial begin
        #200us;
        err_count++;
        $display("Error %0t: watchdog expired", $time);
        conclude();
    end
endmodule : tb
